/* File: common/rlmac_regs.vh */
`ifndef RLMAC_REGS_VH
`define RLMAC_REGS_VH
// ==========================================================
// Register byte offsets
`define RLMAC_CTRL_OFS 12'h000
`define RLMAC_NETID_OFS 12'h004
`define RLMAC_ADDR_OFS 12'h008
`define RLMAC_PORT_OFS 12'h00C
`define RLMAC_STAT_OFS 12'h010
`define RLMAC_TXCMD_OFS 12'h014
// ==========================================================
// Control field positions
`define RLMAC_PROTO_LSB 0
`define RLMAC_PWR_LSB 2
`define RLMAC_RETRY_LSB 4
`define RLMAC_TXPWR_LSB 6
`define RLMAC_IFACE_LSB 9
`define RLMAC_HOP_LSB 12
// ==========================================================
// Reset values
`define RLMAC_CTRL_RST 32'h00000001
`define RLMAC_NETID_RST 15'h0000
`define RLMAC_ADDR_RST 12'h001
`define RLMAC_BAUD_RST 4'h0
`define RLMAC_SDCA_RST 4'h7
// ==========================================================
// Encodings
`define RLMAC_PROTO_TRANSP 2'h0
`define RLMAC_PROTO_INHERIT 2'h1
`define RLMAC_PROTO_NODE 2'h2
`define RLMAC_PWR_ON 2'h0
`define RLMAC_PWR_HALF 2'h1
`define RLMAC_PWR_ONE 2'h2
`define RLMAC_PWR_FOUR 2'h3
`define RLMAC_IF_SDC 3'h0
`define RLMAC_IF_RS232 3'h1
`define RLMAC_IF_USB 3'h2
`define RLMAC_IF_REPEAT 3'h3
`define RLMAC_IF_MEM 3'h4
// ==========================================================
// Timing: clock in Hz, cycles per ms, then milliseconds
`define RLMAC_CLK_HZ 100000000
`define RLMAC_MS_CYC (`RLMAC_CLK_HZ / 1000)
`define RLMAC_LISTEN_MS 13'h0064
`define RLMAC_HALF_PER_MS 13'h01F4
`define RLMAC_ONE_PER_MS 13'h03E8
`define RLMAC_FOUR_PER_MS 13'h0FA0
`define RLMAC_HALF_HDR_MS 13'h02BC
`define RLMAC_ONE_HDR_MS 13'h04B0
`define RLMAC_FOUR_HDR_MS 13'h1068
`define RLMAC_IDLE_MS 13'h1388
`define RLMAC_ACK_WAIT_MS 13'h0032
`endif

/* File: hw/rlmac_ctrl.v */
// The APB register port and the address map were decided locally.
`include "rlmac_regs.vh"
`default_nettype none
// Functional notes
// - Always-on: receiver on, no wakeup header
// - Half-second: 100 ms listen every 500 ms
// - Half-second: 700 ms header after inactivity
// - One-second: 100 ms listen, 1.2 s header
// - Four-second: 100 ms listen, 4.2 s header
// - Unacked packet resent after random delay
// - Retry limits none 0, low 3, med 5, high 7
// - Ack CRC-valid packets addressed to us
// - Transparent passes data; foreign needs no retry
// - Inherit mode takes host address as id
// - Inherit and node modes ack and retry
// - Repeater interface forces node mode, repeats; the code only forces node mode and never repeats a received packet
// - Ignore packets from other hop sequence
// - Network id 0..32767, equal across network
// - Five transmit power levels, 7 to 24 dBm
// - Logger address used only on sync port
// - Baud rate used only on RS-232 port
// - One host interface active; USB always open
module rlmac_ctrl #(
	parameter MS_CYCLES = `RLMAC_MS_CYC
) (
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [11:0] host_addr,
	input wire rx_valid,
	input wire rx_crc_ok,
	input wire [11:0] rx_dst,
	input wire [3:0] rx_hop,
	input wire [14:0] rx_netid,
	input wire rx_is_ack,
	output reg rx_accept_r,
	output reg rx_on_r,
	output reg tx_hdr_r,
	output reg tx_send_r,
	output reg ack_send_r,
	output reg [2:0] tx_pwr_r,
	output reg [2:0] iface_r,
	output reg [3:0] baud_r,
	output reg [3:0] sdc_addr_r,
	output reg usb_cfg_r
);
	localparam ST_IDLE = 3'h0;
	localparam ST_HDR = 3'h1;
	localparam ST_SEND = 3'h2;
	localparam ST_WAIT = 3'h3;
	localparam ST_BACK = 3'h4;

	reg [31:0] ctrl_r;
	reg [14:0] netid_r;
	reg [11:0] addr_r;
	reg [3:0] baud_cfg_r;
	reg [3:0] sdc_cfg_r;
	reg [2:0] st_r;
	reg [12:0] wait_r;
	reg [2:0] tries_r;
	reg [12:0] idle_r;
	reg [1:0] rxs0_r;
	reg [1:0] rxs1_r;
	reg tx_req_r;
	reg fail_r;
	reg done_r;
	wire ms_tick;
	wire [12:0] ms_count;
	wire [15:0] rnd;
	wire [1:0] proto;
	wire [1:0] pwr;
	wire [2:0] iface;
	wire [3:0] hop;
	wire acc;
	wire wr;
	wire rx_ok;
	wire rx_pulse;
	wire [12:0] phase;

	// Retry level to retry count
	function [2:0] retry_max;
		input [1:0] lvl;
		begin
			case (lvl)
			2'h0: retry_max = 3'h0;
			2'h1: retry_max = 3'h3;
			2'h2: retry_max = 3'h5;
			default: retry_max = 3'h7;
			endcase
		end
	endfunction

	// Power mode to listen period in ms
	function [12:0] period_ms;
		input [1:0] m;
		begin
			case (m)
			`RLMAC_PWR_HALF: period_ms = `RLMAC_HALF_PER_MS;
			`RLMAC_PWR_ONE: period_ms = `RLMAC_ONE_PER_MS;
			default: period_ms = `RLMAC_FOUR_PER_MS;
			endcase
		end
	endfunction

	// Power mode to wakeup header in ms
	function [12:0] hdr_ms;
		input [1:0] m;
		begin
			case (m)
			`RLMAC_PWR_HALF: hdr_ms = `RLMAC_HALF_HDR_MS;
			`RLMAC_PWR_ONE: hdr_ms = `RLMAC_ONE_HDR_MS;
			`RLMAC_PWR_FOUR: hdr_ms = `RLMAC_FOUR_HDR_MS;
			default: hdr_ms = 13'h0000;
			endcase
		end
	endfunction

	rlmac_timebase #(
		.MS_CYCLES(MS_CYCLES)
	) u_tb (
		.sys_clk(sys_clk),
		.rst(rst),
		.ms_tick_r(ms_tick),
		.ms_count_r(ms_count)
	);

	rlmac_lfsr u_rnd (
		.sys_clk(sys_clk),
		.rst(rst),
		.rnd_r(rnd)
	);

	// ======================================================
	// Configuration decode
	assign proto = (iface == `RLMAC_IF_REPEAT) ? `RLMAC_PROTO_NODE
		: ctrl_r[`RLMAC_PROTO_LSB+1:`RLMAC_PROTO_LSB];
	assign pwr = ctrl_r[`RLMAC_PWR_LSB+1:`RLMAC_PWR_LSB];
	assign iface = ctrl_r[`RLMAC_IFACE_LSB+2:`RLMAC_IFACE_LSB];
	assign hop = ctrl_r[`RLMAC_HOP_LSB+3:`RLMAC_HOP_LSB];
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign phase = ms_count % period_ms(pwr);

	// Valid and CRC flags come from the modem domain: two stages
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rxs0_r <= 2'h0;
			rxs1_r <= 2'h0;
		end
		else
		begin
			rxs0_r <= {rx_valid, rx_crc_ok};
			rxs1_r <= rxs0_r;
		end
	end
	assign rx_pulse = rxs1_r[1];
	// Network id and hop sequence filter
	assign rx_ok = rx_pulse && rx_netid == netid_r && rx_hop == hop;

	// ======================================================
	// APB slave, zero wait states
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r <= `RLMAC_CTRL_RST;
			netid_r <= `RLMAC_NETID_RST;
			addr_r <= `RLMAC_ADDR_RST;
			baud_cfg_r <= `RLMAC_BAUD_RST;
			sdc_cfg_r <= `RLMAC_SDCA_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			tx_req_r <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (done_r)
				tx_req_r <= 1'b0;
			if (psel & ~penable)
			begin
				case (paddr)
				`RLMAC_CTRL_OFS: prdata <= ctrl_r;
				`RLMAC_NETID_OFS: prdata <= {17'h00000, netid_r};
				`RLMAC_ADDR_OFS: prdata <= {20'h00000, addr_r};
				`RLMAC_PORT_OFS: prdata <= {24'h000000, sdc_cfg_r, baud_cfg_r};
				`RLMAC_STAT_OFS: prdata <= {24'h000000, fail_r, tries_r,
					1'b0, st_r};
				`RLMAC_TXCMD_OFS: prdata <= {31'h00000000, tx_req_r};
				default:
				begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
				endcase
			end
			if (wr && pready)
			begin
				case (paddr)
				`RLMAC_CTRL_OFS: ctrl_r <= pwdata;
				`RLMAC_NETID_OFS: netid_r <= pwdata[14:0];
				`RLMAC_ADDR_OFS: addr_r <= pwdata[11:0];
				`RLMAC_PORT_OFS:
				begin
					baud_cfg_r <= pwdata[3:0];
					sdc_cfg_r <= pwdata[7:4];
				end
				`RLMAC_TXCMD_OFS: tx_req_r <= pwdata[0];
				default: ;
				endcase
			end
			// Address taken from host in inherit mode
			if (proto == `RLMAC_PROTO_INHERIT)
				addr_r <= host_addr;
		end
	end

	// ======================================================
	// Transmit, ack and retry sequencer
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			wait_r <= 13'h0000;
			tries_r <= 3'h0;
			idle_r <= 13'h0000;
			fail_r <= 1'b0;
			done_r <= 1'b0;
			tx_hdr_r <= 1'b0;
			tx_send_r <= 1'b0;
			ack_send_r <= 1'b0;
			rx_accept_r <= 1'b0;
		end
		else
		begin
			tx_send_r <= 1'b0;
			done_r <= 1'b0;
			rx_accept_r <= rx_ok;
			// Ack a valid packet addressed here, not in transparent
			ack_send_r <= rx_ok && rxs1_r[0] && !rx_is_ack
				&& rx_dst == addr_r
				&& proto != `RLMAC_PROTO_TRANSP;
			if (rx_ok || tx_send_r)
				idle_r <= 13'h0000;
			else if (ms_tick && idle_r != `RLMAC_IDLE_MS)
				idle_r <= idle_r + 13'h0001;
			if (ms_tick && wait_r != 13'h0000)
				wait_r <= wait_r - 13'h0001;
			case (st_r)
			ST_IDLE:
			begin
				if (tx_req_r && !done_r)
				begin
					tries_r <= 3'h0;
					fail_r <= 1'b0;
					// Header only after inactivity, never always-on
					if (pwr != `RLMAC_PWR_ON
						&& idle_r == `RLMAC_IDLE_MS)
					begin
						st_r <= ST_HDR;
						wait_r <= hdr_ms(pwr);
						tx_hdr_r <= 1'b1;
					end
					else
						st_r <= ST_SEND;
				end
			end
			ST_HDR:
				if (wait_r == 13'h0000)
				begin
					tx_hdr_r <= 1'b0;
					st_r <= ST_SEND;
				end
			ST_SEND:
			begin
				tx_send_r <= 1'b1;
				wait_r <= `RLMAC_ACK_WAIT_MS;
				// Transparent mode sends once, no ack expected
				if (proto == `RLMAC_PROTO_TRANSP)
				begin
					st_r <= ST_IDLE;
					done_r <= 1'b1;
				end
				else
					st_r <= ST_WAIT;
			end
			ST_WAIT:
				if (rx_ok && rx_is_ack)
				begin
					st_r <= ST_IDLE;
					done_r <= 1'b1;
				end
				else if (wait_r == 13'h0000)
				begin
					if (tries_r == retry_max(ctrl_r[`RLMAC_RETRY_LSB+1:
						`RLMAC_RETRY_LSB]))
					begin
						fail_r <= 1'b1;
						st_r <= ST_IDLE;
						done_r <= 1'b1;
					end
					else
					begin
						tries_r <= tries_r + 3'h1;
						wait_r <= {7'h00, rnd[5:0]} + 13'h0001;
						st_r <= ST_BACK;
					end
				end
			ST_BACK:
				if (wait_r == 13'h0000)
					st_r <= ST_SEND;
			default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ======================================================
	// Receiver duty cycle and port settings
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_on_r <= 1'b1;
			tx_pwr_r <= 3'h0;
			iface_r <= `RLMAC_IF_SDC;
			baud_r <= `RLMAC_BAUD_RST;
			sdc_addr_r <= `RLMAC_SDCA_RST;
			usb_cfg_r <= 1'b1;
		end
		else
		begin
			rx_on_r <= pwr == `RLMAC_PWR_ON
				|| phase < `RLMAC_LISTEN_MS
				|| st_r == ST_WAIT;
			// Five levels: 7, 15, 18, 21, 24 dBm
			tx_pwr_r <= (ctrl_r[`RLMAC_TXPWR_LSB+2:`RLMAC_TXPWR_LSB] > 3'h4)
				? 3'h4 : ctrl_r[`RLMAC_TXPWR_LSB+2:`RLMAC_TXPWR_LSB];
			iface_r <= iface;
			usb_cfg_r <= 1'b1;
			if (iface == `RLMAC_IF_RS232)
				baud_r <= baud_cfg_r;
			if (iface == `RLMAC_IF_SDC)
				sdc_addr_r <= sdc_cfg_r;
		end
	end
endmodule // rlmac_ctrl
`default_nettype wire

/* File: hw/rlmac_lfsr.v */
`default_nettype none
// Free-running 16-bit LFSR for random back-off
module rlmac_lfsr (
	input wire sys_clk,
	input wire rst,
	output reg [15:0] rnd_r
);
	// ======================================================
	// Shift
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rnd_r <= 16'hACE1;
		else
			rnd_r <= {rnd_r[14:0],
				rnd_r[15] ^ rnd_r[13] ^ rnd_r[12] ^ rnd_r[10]};
	end
endmodule // rlmac_lfsr
`default_nettype wire

/* File: hw/rlmac_timebase.v */
`include "rlmac_regs.vh"
`default_nettype none
// Millisecond tick and ms counter from the system clock
module rlmac_timebase #(
	parameter MS_CYCLES = `RLMAC_MS_CYC
) (
	input wire sys_clk,
	input wire rst,
	output reg ms_tick_r,
	output reg [12:0] ms_count_r
);
	reg [26:0] div_r;
	// ======================================================
	// Divider
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			div_r <= 27'h0000000;
			ms_tick_r <= 1'b0;
			ms_count_r <= 13'h0000;
		end
		else if (div_r == MS_CYCLES[26:0] - 27'h0000001)
		begin
			div_r <= 27'h0000000;
			ms_tick_r <= 1'b1;
			ms_count_r <= ms_count_r + 13'h0001;
		end
		else
		begin
			div_r <= div_r + 27'h0000001;
			ms_tick_r <= 1'b0;
		end
	end
endmodule // rlmac_timebase
`default_nettype wire

/* File: sim/rlmac_ctrl_asserts.sv */
`default_nettype none
// ====
// Port checker of the link controller
module rlmac_ctrl_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic rx_valid,
	input wire logic [3:0] rx_hop,
	input wire logic rx_accept_r,
	input wire logic rx_on_r,
	input wire logic tx_hdr_r,
	input wire logic [2:0] tx_pwr_r,
	input wire logic [2:0] iface_r,
	input wire logic [3:0] baud_r,
	input wire logic [3:0] sdc_addr_r,
	input wire logic usb_cfg_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ctl_r;
	logic [7:0] prt_r;
	logic [1:0] age_r;
	wire wr = psel && penable && pwrite && pready;
	wire ok = age_r == 2'h3;
	wire [1:0] pm = ctl_r[3:2];
	wire [2:0] ifc = ctl_r[11:9];
	// Shadow of written settings, cycles since a write
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			ctl_r <= 16'h0001;
			prt_r <= 8'h70;
			age_r <= 2'h3;
		end
		else
		begin
			if (wr && paddr == 12'h000)
				ctl_r <= pwdata[15:0];
			if (wr && paddr == 12'h00C)
				prt_r <= pwdata[7:0];
			if (wr)
				age_r <= 2'h0;
			else if (!ok)
				age_r <= age_r + 2'h1;
		end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rx_always: assert property (ok && pm == 2'h0 |-> rx_on_r)
		else $error("receiver off");
	a_no_header: assert property (ok && pm == 2'h0 |-> !tx_hdr_r)
		else $error("header sent");
	a_txpwr_sel: assert property (ok |-> tx_pwr_r == ctl_r[8:6])
		else $error("power level");
	a_iface_sel: assert property (ok |-> iface_r == ifc)
		else $error("interface");
	a_baud_use: assert property (ok && ifc == 3'h1
		|-> baud_r == prt_r[3:0])
		else $error("baud");
	a_sdc_use: assert property (ok && !ifc
		|-> sdc_addr_r == prt_r[7:4])
		else $error("sync address");
	a_usb_open: assert property (usb_cfg_r)
		else $error("usb closed");
	a_hop_drop: assert property ($rose(rx_valid) && ok
		&& rx_hop != ctl_r[15:12] |=> !rx_accept_r [*5])
		else $error("foreign hop accepted");
endmodule // rlmac_ctrl_chk
bind rlmac_ctrl rlmac_ctrl_chk u_rlmac_ctrl_chk (.*);
`default_nettype wire

/* File: sim/rlmac_peer.sv */
`default_nettype none
// ====
// Far radio: frames packets and acknowledges sends
module rlmac_peer (
	input wire logic sys_clk,
	input wire logic tx_send_r,
	input wire logic ack_on,
	input wire logic [11:0] own,
	output logic rx_valid,
	output logic rx_crc_ok,
	output logic [11:0] rx_dst,
	output logic [3:0] rx_hop,
	output logic [14:0] rx_netid,
	output logic rx_is_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	// Fields held around a one-cycle strobe, then scrambled
	task automatic send(input logic [11:0] d, input logic [3:0] h,
		input logic [14:0] n, input logic c, input logic a);
		{rx_dst, rx_hop, rx_netid, rx_crc_ok, rx_is_ack} <= {d, h, n, c, a};
		repeat (3) @(posedge sys_clk);
		rx_valid <= 1'b1;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		{rx_dst, rx_hop, rx_netid, rx_crc_ok, rx_is_ack} <= ~{d, h, n, c, a};
	endtask
	// Idle line
	initial
	begin
		rx_valid = 1'b0;
		{rx_dst, rx_hop, rx_netid, rx_crc_ok, rx_is_ack} = '0;
	end
	// Acknowledge on the shared hop sequence and network
	always @(posedge sys_clk)
		if (tx_send_r && ack_on)
			send(own, 4'h5, 15'h7FFF, 1'b1, 1'b1);
endmodule // rlmac_peer
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
// ====
// Bench of the link controller
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 2;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err, ack_on;
	logic rx_valid, rx_crc_ok, rx_is_ack, rx_accept_r, rx_on_r, tx_hdr_r;
	logic tx_send_r, ack_send_r, usb_cfg_r;
	logic [11:0] paddr, host_addr, rx_dst, own;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] rx_hop, baud_r, sdc_addr_r;
	logic [14:0] rx_netid;
	logic [2:0] tx_pwr_r, iface_r;
	int n_mismatch, check_count, cyc, sends;
	rlmac_ctrl #(.MS_CYCLES(MS)) u_rlmac_ctrl (.*);
	rlmac_peer u_rlmac_peer (.*);
	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Send count and hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (tx_send_r === 1'b1)
			sends++;
		if (cyc == 90000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	task automatic give_verdict;
		$display("Mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	function automatic logic [31:0] ctl(int pr, pm, rt, tp, fc);
		return {16'h0, 4'h5, 3'(fc), 3'(tp), 2'(rt), 2'(pm), 2'(pr)};
	endfunction
	task automatic wait_idle;
		do
			apb(1'b0, 12'h014, 32'h0);
		while (rd[0] !== 1'b0);
	endtask
	task automatic t_regs;
		logic [31:0] rv [4] = '{32'h1, 32'h0, 32'h2AB, 32'h70};
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 12'(4 * i), 32'h0);
			chk("reset value", rv[i], rd);
		end
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, 12'h004, 32'hFFFF);
		apb(1'b0, 12'h004, 32'h0);
		chk("netid", 32'h7FFF, rd);
		apb(1'b1, 12'h00C, 32'hA3);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 12'h000, ctl(2, 0, 0, i, i));
			repeat (3) @(posedge sys_clk);
			chk("tx power", i, tx_pwr_r);
			chk("iface", i, iface_r);
			if (i < 2)
				chk("port", i ? 3 : 10, i ? baud_r : sdc_addr_r);
		end
		// Node mode now, so the written address sticks
		apb(1'b1, 12'h008, 32'h123);
		apb(1'b0, 12'h008, 32'h0);
		chk("address", 32'h123, rd);
	endtask
	task automatic t_duty;
		int per [3] = '{500, 1000, 4000};
		int hdr [3] = '{700, 1200, 4200};
		int n;
		for (int m = 0; m < 3; m++)
		begin
			apb(1'b1, 12'h000, ctl(2, m + 1, 0, 0, 0));
			repeat (4) @(posedge sys_clk);
			n = 0;
			repeat (per[m] * MS) @(posedge sys_clk) n += rx_on_r === 1'b1;
			chk("listen", 100 * MS, n);
		end
		ack_on <= 1'b1;
		for (int m = 0; m < 3; m++)
		begin
			apb(1'b1, 12'h000, ctl(2, m + 1, 0, 0, 0));
			repeat (5000 * MS + 20) @(posedge sys_clk);
			sends = 0;
			apb(1'b1, 12'h014, 32'h1);
			n = 0;
			while (tx_hdr_r !== 1'b1) @(posedge sys_clk);
			for (n = 0; tx_hdr_r === 1'b1; n++) @(posedge sys_clk);
			chk("early send", 0, sends);
			chk("header", 1, n >= (hdr[m] - 1) * MS
				&& n <= (hdr[m] + 1) * MS);
			wait_idle;
			chk("acked send", 1, sends);
		end
	endtask
	task automatic t_retry;
		int pr [7] = '{2, 2, 2, 1, 0, 2, 0};
		int rt [7] = '{0, 1, 2, 3, 3, 3, 1};
		int ex [7] = '{1, 4, 6, 8, 1, 1, 4};
		for (int i = 0; i < 7; i++)
		begin
			ack_on <= i == 5;
			// Last case: repeater interface overrides transparent
			apb(1'b1, 12'h000, ctl(pr[i], 0, rt[i], 0, i == 6 ? 3 : 0));
			sends = 0;
			apb(1'b1, 12'h014, 32'h1);
			wait_idle;
			chk("sends", ex[i], sends);
		end
	endtask
	task automatic t_rx;
		logic [11:0] ds [6] = '{12'h123, 12'h123, 12'h123, 12'h123, 12'h456,
			12'h2AB};
		logic [5:0] acc = 6'b111001;
		logic [5:0] ack = 6'b100001;
		logic a, k;
		// Inherit mode earlier replaced the address: restore it
		apb(1'b1, 12'h000, ctl(2, 0, 0, 0, 0));
		apb(1'b1, 12'h008, 32'h123);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, 12'h000, ctl(i == 5 ? 1 : 2, 0, 0, 0, 0));
			{a, k} = 2'h0;
			fork
				u_rlmac_peer.send(ds[i], i == 1 ? 4'hA : 4'h5,
					i == 2 ? 15'h1234 : 15'h7FFF, i != 3, 1'b0);
				repeat (12)
				begin
					@(posedge sys_clk);
					a |= rx_accept_r;
					k |= ack_send_r;
				end
			join
			chk("accept", acc[i], a);
			chk("ack", ack[i], k);
		end
	endtask
	// Reset, then the scenarios
	initial
	begin
		{rst, psel, penable, pwrite, ack_on} = 5'h10;
		{paddr, pwdata, host_addr, own} = {12'h0, 32'h0, 12'h2AB, 12'h123};
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_duty;
		t_retry;
		t_rx;
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
